// ### common/osl_pkg.sv
package osl_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_SLOT_LO = 12'h004;
   localparam logic [11:0] OFS_SLOT_HI = 12'h008;
   localparam logic [11:0] OFS_SCDEF = 12'h00C;
   localparam logic [11:0] OFS_STATUS = 12'h010;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTRL_LOADDEF = 0;
   localparam int CTRL_LC_BASE = 8;
   localparam int LC_STRIDE = 8;
   localparam int LC_EN = 0;
   localparam int LC_OP = 1;
   localparam int LC_INV = 3;
   localparam int LC_REC = 4;
   localparam int LC_CLOSE = 6;
   localparam int SLOT_STRIDE = 8;
   localparam int SLOT_W = 7;
   localparam int ST_CONTACT = 0;
   localparam int ST_SWITCH = 1;
   localparam int ST_GATE = 4;
   localparam int ST_LCSET = 8;
   localparam int ST_LCVAL = 12;
   localparam int ST_SCENE = 16;
   localparam int SCENE_STORE = 7;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam logic [31:0] SLOT_RST = 32'h0000_0000;
   localparam logic [7:0] SCDEF_RST = 8'hFF;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      OSL_AND = 2'h0,
      OSL_OR = 2'h1,
      OSL_XOR = 2'h2,
      OSL_GATE = 2'h3
   } osl_op_t;
   typedef enum logic [1:0] {
      OSL_NOWRITE = 2'h0,
      OSL_WRITE0 = 2'h1,
      OSL_WRITE1 = 2'h2
   } osl_rec_t;
   typedef struct packed {
      logic valid;
      logic value;
   } osl_bit_tg_t;
   typedef struct packed {
      logic valid;
      logic [7:0] code;
   } osl_scene_tg_t;
endpackage

// ### verilog/osl_output_ctrl.sv
// How it works
// - One scene byte carries number and store flag.
// - Eight slots, number 1..64, zero unused.
// - Matching slots recall or store on telegram.
// - Slot default state ON or OFF, ON default.
// - Option loads defaults after tool reset.
// - Recall restarts timing and recomputes logic.
// - Two logic inputs, each enabled separately.
// - Recompute on value; input one, then two.
// - Operation AND, OR, XOR or GATE.
// - Optional result inversion per stage, default off.
// - Recovery leaves input unwritten, or forces 0/1.
// - Switch holds 0; contact driven at next write.
// - Logic values saved on fail, restored on recovery.
// - Bus reset keeps logic input values.
// - Never-written logic input is bypassed.
// - Gate closing polarity is configurable.
// - Closed gate holds; open gate passes input.
// - Reopened gate holds until new value.
// - Gate forced closed by fail, stays after recovery.
// - Input two has the same options.
// - Stored scene states kept until reset.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module osl_output_ctrl #(
   parameter int NUM_SLOTS = 8,
   parameter int NUM_LC = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [osl_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Telegrams from the building bus
   input wire osl_pkg::osl_scene_tg_t sceneTg,
   input wire osl_pkg::osl_bit_tg_t switchTg,
   input wire osl_pkg::osl_bit_tg_t [NUM_LC-1:0] lcTg,
   // Bus and tool events
   input wire logic busFail,
   input wire logic busRecover,
   input wire logic busReset,
   input wire logic toolReset,
   // Output side
   output logic contactOut,
   output logic switchValue,
   output logic timerRestart,
   output logic [NUM_LC-1:0] gateClosed
);
   import osl_pkg::*;

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   logic [31:0] ctrl_r;
   logic [SLOT_W-1:0] slotNum_r [NUM_SLOTS];
   logic [NUM_SLOTS-1:0] scDef_r;
   logic [NUM_SLOTS-1:0] sceneState_r;
   logic [31:0] prdata_r;

   // ---------------------------------------------------------------
   // Object state
   // ---------------------------------------------------------------
   logic switchObj_r;
   logic [NUM_LC-1:0] lcVal_r;
   logic [NUM_LC-1:0] lcSet_r;
   logic [NUM_LC-1:0] savedVal_r;
   logic [NUM_LC-1:0] savedSet_r;
   logic [NUM_LC-1:0] gateForce_r;
   logic [NUM_LC-1:0] gateOut_r;
   logic outState_r;
   logic evalPend_r;
   logic gateUpd_r;
   logic timerRestart_r;

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   wire logic setupPh = psel && !penable;
   wire logic accessPh = psel && penable;
   wire logic hitCtrl = (paddr == OFS_CTRL);
   wire logic hitLo = (paddr == OFS_SLOT_LO);
   wire logic hitHi = (paddr == OFS_SLOT_HI);
   wire logic hitDef = (paddr == OFS_SCDEF);
   wire logic hitStat = (paddr == OFS_STATUS);
   wire logic hitAny = hitCtrl || hitLo || hitHi || hitDef || hitStat;
   wire logic wrEn = accessPh && pwrite;
   wire logic loadDef = ctrl_r[CTRL_LOADDEF];

   // Status writes are refused so software sees a misdirected write.
   assign pready = 1'b1;
   assign pslverr = accessPh && (!hitAny || (pwrite && hitStat));
   assign prdata = prdata_r;
   logic [31:0] slotLoWord;
   logic [31:0] slotHiWord;
   logic [31:0] statWord;
   logic [31:0] readMux;
   always_comb begin
      slotLoWord = '0;
      slotHiWord = '0;
      for (int k = 0; k < 4; k++) begin
         slotLoWord[k*SLOT_STRIDE +: SLOT_W] = slotNum_r[k];
         slotHiWord[k*SLOT_STRIDE +: SLOT_W] = slotNum_r[k+4];
      end
      statWord = '0;
      statWord[ST_CONTACT] = outState_r;
      statWord[ST_SWITCH] = switchObj_r;
      statWord[ST_GATE +: NUM_LC] = gateClosed;
      statWord[ST_LCSET +: NUM_LC] = lcSet_r;
      statWord[ST_LCVAL +: NUM_LC] = lcVal_r;
      statWord[ST_SCENE +: NUM_SLOTS] = sceneState_r;
      if (hitCtrl) begin
         readMux = ctrl_r;
      end else if (hitLo) begin
         readMux = slotLoWord;
      end else if (hitHi) begin
         readMux = slotHiWord;
      end else if (hitDef) begin
         readMux = {{(32-NUM_SLOTS){1'b0}}, scDef_r};
      end else if (hitStat) begin
         readMux = statWord;
      end else begin
         readMux = '0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r <= CTRL_RST;
         scDef_r <= SCDEF_RST[NUM_SLOTS-1:0];
         prdata_r <= '0;
         for (int k = 0; k < NUM_SLOTS; k++) begin
            slotNum_r[k] <= SLOT_RST[SLOT_W-1:0];
         end
      end else begin
         if (setupPh && !pwrite) begin
            prdata_r <= readMux;
         end
         if (wrEn && hitCtrl) begin
            ctrl_r <= pwdata;
         end
         if (wrEn && hitDef) begin
            scDef_r <= pwdata[NUM_SLOTS-1:0];
         end
         for (int k = 0; k < 4; k++) begin
            if (wrEn && hitLo) begin
               slotNum_r[k] <= pwdata[k*SLOT_STRIDE +: SLOT_W];
            end
            if (wrEn && hitHi) begin
               slotNum_r[k+4] <= pwdata[k*SLOT_STRIDE +: SLOT_W];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Scene decode
   // ---------------------------------------------------------------
   // The low six bits carry N-1, so the slot number is one higher.
   wire logic sceneStore = sceneTg.code[SCENE_STORE];
   wire logic [SLOT_W-1:0] sceneNo = {1'b0, sceneTg.code[5:0]} + 7'h01;
   logic [NUM_SLOTS-1:0] slotHit;

   genvar gs;
   generate
      for (gs = 0; gs < NUM_SLOTS; gs++) begin : g_slot
         assign slotHit[gs] = sceneTg.valid && (slotNum_r[gs] != '0)
                            && (slotNum_r[gs] == sceneNo);
      end
   endgenerate
   wire logic recallHit = (|slotHit) && !sceneStore;
   wire logic storeHit = (|slotHit) && sceneStore;
   logic recallVal;
   always_comb begin
      recallVal = 1'b0;
      for (int k = NUM_SLOTS - 1; k >= 0; k--) begin
         if (slotHit[k]) begin
            recallVal = sceneState_r[k];
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sceneState_r <= SCDEF_RST[NUM_SLOTS-1:0];
      end else if (toolReset && loadDef) begin
         sceneState_r <= scDef_r;
      end else if (storeHit) begin
         for (int k = 0; k < NUM_SLOTS; k++) begin
            if (slotHit[k]) begin
               sceneState_r[k] <= outState_r;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Logic stages
   // ---------------------------------------------------------------
   function automatic logic stage_f(input logic a, input logic b,
                                    input logic act, input logic inv,
                                    input osl_op_t op, input logic gq);
      logic r;
      r = a;
      case (op)
         OSL_AND: r = a & b;
         OSL_OR: r = a | b;
         OSL_XOR: r = a ^ b;
         default: r = gq;
      endcase
      stage_f = act ? (r ^ inv) : a;
   endfunction
   logic [NUM_LC:0] stageIn;
   logic [NUM_LC-1:0] gateQ;
   logic [NUM_LC-1:0] lcEn;
   logic [NUM_LC-1:0] lcInv;
   logic [NUM_LC-1:0] lcClose;
   logic [NUM_LC-1:0] lcForce;
   logic [NUM_LC-1:0] lcForceVal;
   logic [NUM_LC-1:0] lcWr;
   assign stageIn[0] = switchObj_r;
   genvar gl;
   generate
      for (gl = 0; gl < NUM_LC; gl++) begin : g_lc
         localparam int B = CTRL_LC_BASE + gl * LC_STRIDE;
         wire osl_op_t op = osl_op_t'(ctrl_r[B+LC_OP +: 2]);
         wire osl_rec_t rec = osl_rec_t'(ctrl_r[B+LC_REC +: 2]);
         assign lcEn[gl] = ctrl_r[B+LC_EN];
         assign lcInv[gl] = ctrl_r[B+LC_INV];
         assign lcClose[gl] = ctrl_r[B+LC_CLOSE];
         assign lcForce[gl] = (rec != OSL_NOWRITE);
         assign lcForceVal[gl] = (rec == OSL_WRITE1);
         assign lcWr[gl] = lcTg[gl].valid;
         assign gateClosed[gl] = gateForce_r[gl]
            || (lcSet_r[gl] && (lcVal_r[gl] == lcClose[gl]));
         // A closed gate keeps its held value; an open one takes a
         // new value only when one arrives.
         assign gateQ[gl] = (gateUpd_r && !gateClosed[gl])
            ? stageIn[gl] : gateOut_r[gl];
         assign stageIn[gl+1] = stage_f(stageIn[gl], lcVal_r[gl],
            lcEn[gl] && lcSet_r[gl], lcInv[gl], op, gateQ[gl]);
      end
   endgenerate

   // ---------------------------------------------------------------
   // Object updates
   // ---------------------------------------------------------------
   wire logic anyForce = busRecover && |(lcForce & lcEn);
   wire logic switchEvt = switchTg.valid || recallHit;
   wire logic evalEvt = switchEvt || (|lcWr) || anyForce;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         switchObj_r <= 1'b0;
         lcVal_r <= '0;
         lcSet_r <= '0;
         savedVal_r <= '0;
         savedSet_r <= '0;
         gateForce_r <= '0;
      end else begin
         if (busFail) begin
            savedVal_r <= lcVal_r;
            savedSet_r <= lcSet_r;
         end
         if (busRecover || busReset) begin
            switchObj_r <= 1'b0;
         end
         if (switchTg.valid) begin
            switchObj_r <= switchTg.value;
         end
         if (recallHit) begin
            switchObj_r <= recallVal;
         end
         for (int i = 0; i < NUM_LC; i++) begin
            if (busRecover) begin
               lcVal_r[i] <= lcForce[i] ? lcForceVal[i]
                           : savedVal_r[i];
               lcSet_r[i] <= lcForce[i] || savedSet_r[i];
            end
            if (lcWr[i]) begin
               lcVal_r[i] <= lcTg[i].value;
               lcSet_r[i] <= 1'b1;
               gateForce_r[i] <= 1'b0;
            end
            // Failure is applied last so it wins over a same-cycle write.
            if (busFail) begin
               gateForce_r[i] <= 1'b1;
            end
         end
      end
   end
   // Bus reset leaves the logic objects alone and only clears the
   // switch object above.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         evalPend_r <= 1'b0;
         gateUpd_r <= 1'b0;
         timerRestart_r <= 1'b0;
         outState_r <= 1'b0;
         gateOut_r <= '0;
      end else begin
         evalPend_r <= evalEvt;
         gateUpd_r <= switchEvt;
         timerRestart_r <= recallHit;
         if (evalPend_r) begin
            outState_r <= stageIn[NUM_LC];
            gateOut_r <= gateQ;
         end
      end
   end

   assign contactOut = outState_r;
   assign switchValue = switchObj_r;
   assign timerRestart = timerRestart_r;
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_recall_restart: assert property (@(posedge clk) disable iff (sys_rst)
      recallHit |=> timerRestart)
      else $error("Recall did not restart timing.");
   a_plain_switch: assert property (@(posedge clk) disable iff (sys_rst)
      (switchTg.valid && !sceneTg.valid && !busRecover && !busReset
       && lcEn == '0) ##1 !evalEvt |=> contactOut == $past(switchTg.value, 2))
      else $error("Switch value did not reach contact.");
   a_store_capture: assert property (@(posedge clk) disable iff (sys_rst)
      (storeHit && slotHit[0] && !toolReset)
      |=> sceneState_r[0] == $past(outState_r))
      else $error("Store missed the output state.");
   a_default_load: assert property (@(posedge clk) disable iff (sys_rst)
      (toolReset && loadDef) |=> sceneState_r == $past(scDef_r))
      else $error("Defaults not loaded after tool reset.");
   a_reset_keeps: assert property (@(posedge clk) disable iff (sys_rst)
      (busReset && !busRecover && lcWr == '0)
      |=> lcVal_r == $past(lcVal_r))
      else $error("Bus reset changed logic values.");
   a_fail_closes: assert property (@(posedge clk) disable iff (sys_rst)
      busFail |=> gateClosed == {NUM_LC{1'b1}})
      else $error("Gate not closed after failure.");
   a_recover_restore: assert property (@(posedge clk)
      disable iff (sys_rst)
      (busRecover && !lcForce[0] && !lcWr[0] && !busFail)
      |=> lcVal_r[0] == $past(savedVal_r[0]))
      else $error("Logic input one not restored.");
   a_recover_zero: assert property (@(posedge clk) disable iff (sys_rst)
      (busRecover && !switchEvt) |=> !switchValue)
      else $error("Switch object not zero after recovery.");
   a_gate_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (evalPend_r && gateClosed[0])
      |=> gateOut_r[0] == $past(gateOut_r[0]))
      else $error("Closed gate changed its output.");

endmodule // osl_output_ctrl
`default_nettype wire

// ### tb/osl_tg_sender.sv
`timescale 1ns/1ps
`default_nettype none
module osl_tg_sender (
   // Clock
   input wire logic clk,
   // Telegrams
   output var osl_pkg::osl_scene_tg_t sceneTg,
   output var osl_pkg::osl_bit_tg_t switchTg,
   output var osl_pkg::osl_bit_tg_t [1:0] lcTg,
   // Bus and tool events
   output var logic busFail,
   output var logic busRecover,
   output var logic busReset,
   output var logic toolReset
);
   import osl_pkg::*;
   // ---------------------------------------------------------------
   // Telegram senders
   // ---------------------------------------------------------------
   // Idle data is inverted so a design reading it outside valid fails.
   // Requests reach the pins one edge later, so pins move only at edges.
   osl_scene_tg_t sceneReq;
   osl_bit_tg_t switchReq;
   osl_bit_tg_t [1:0] lcReq;
   logic [3:0] evtReq;
   initial begin
      sceneReq = '0;
      switchReq = '0;
      lcReq = '0;
      evtReq = 4'h0;
   end
   always @(posedge clk) begin
      sceneTg <= sceneReq;
      switchTg <= switchReq;
      lcTg <= lcReq;
      {busFail, busRecover, busReset, toolReset} <= evtReq;
   end
   task automatic scene(input logic [7:0] code);
      @(posedge clk);
      sceneReq <= '{valid: 1'b1, code: code};
      @(posedge clk);
      sceneReq <= '{valid: 1'b0, code: ~code};
      @(posedge clk);
   endtask
   task automatic recall(input int n);
      scene({2'h0, 6'(n - 1)});
   endtask
   task automatic store(input int n);
      scene({2'h2, 6'(n - 1)});
   endtask
   task automatic sw(input logic v);
      @(posedge clk);
      switchReq <= '{valid: 1'b1, value: v};
      @(posedge clk);
      switchReq <= '{valid: 1'b0, value: ~v};
      @(posedge clk);
   endtask
   task automatic lc(input int i, input logic v);
      @(posedge clk);
      lcReq[i] <= '{valid: 1'b1, value: v};
      @(posedge clk);
      lcReq[i] <= '{valid: 1'b0, value: ~v};
      @(posedge clk);
   endtask
   // Event 0 fail, 1 recovery, 2 bus reset, 3 tool reset.
   task automatic pulse(input int k);
      @(posedge clk);
      evtReq <= 4'h8 >> k;
      @(posedge clk);
      evtReq <= 4'h0;
      @(posedge clk);
   endtask
endmodule // osl_tg_sender
`default_nettype wire

// ### tb/output_scene_logic_gate_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module output_scene_logic_gate_tb_top;
   import osl_pkg::*;
   logic clk = 1'b0;
   logic sys_rst;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   osl_scene_tg_t sceneTg;
   osl_bit_tg_t switchTg;
   osl_bit_tg_t [1:0] lcTg;
   logic busFail, busRecover, busReset, toolReset;
   logic contactOut, switchValue, timerRestart;
   logic [1:0] gateClosed;
   logic [31:0] rd;
   logic er;
   int err_count = 0;
   int check_count = 0;
   int cycles = 0;
   always #20 clk = ~clk;
   osl_output_ctrl dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sceneTg(sceneTg), .switchTg(switchTg), .lcTg(lcTg),
      .busFail(busFail), .busRecover(busRecover), .busReset(busReset),
      .toolReset(toolReset), .contactOut(contactOut),
      .switchValue(switchValue), .timerRestart(timerRestart),
      .gateClosed(gateClosed));
   osl_tg_sender snd (.clk(clk), .sceneTg(sceneTg), .switchTg(switchTg),
      .lcTg(lcTg), .busFail(busFail), .busRecover(busRecover),
      .busReset(busReset), .toolReset(toolReset));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic finish_test();
      if (err_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer.
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Contact follows a telegram one edge after the object registers.
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask
   function automatic logic f(input int op, input logic x, input logic y);
      case (op)
         0: return x & y;
         1: return x | y;
         default: return x ^ y;
      endcase
   endfunction
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rd, CTRL_RST);
      apb(1'b0, OFS_SLOT_LO, 32'h0);
      chk(rd, SLOT_RST);
      apb(1'b0, OFS_SLOT_HI, 32'h0);
      chk(rd, SLOT_RST);
      apb(1'b0, OFS_SCDEF, 32'h0);
      chk(rd, {24'h0, SCDEF_RST});
      apb(1'b0, 12'h014, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      apb(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
      chk({31'h0, er}, 32'h1);
   endtask
   task automatic t_unassigned();
      apb(1'b1, OFS_CTRL, 32'h0000_0101);
      snd.sw(1'b1);
      settle();
      chk({31'h0, contactOut}, 32'h1);
   endtask
   task automatic t_logic();
      for (int op = 0; op < 3; op++) begin
         for (int inv = 0; inv < 2; inv++) begin
            apb(1'b1, OFS_CTRL, 32'h0005_0101 | (32'(op) << 9)
                | (32'(inv) << 11));
            for (int v = 0; v < 8; v++) begin
               snd.lc(0, v[0]);
               snd.lc(1, v[1]);
               snd.sw(v[2]);
               settle();
               chk({31'h0, contactOut}, {31'h0, f(op, v[2], v[0])
                   ^ inv[0] ^ v[1]});
            end
         end
      end
   endtask
   task automatic t_gate();
      apb(1'b1, OFS_CTRL, 32'h0000_4701);
      snd.lc(0, 1'b0);
      snd.sw(1'b1);
      settle();
      chk({30'h0, gateClosed[0], contactOut}, 32'h1);
      snd.lc(0, 1'b1);
      snd.sw(1'b0);
      settle();
      chk({30'h0, gateClosed[0], contactOut}, 32'h3);
      snd.lc(0, 1'b0);
      settle();
      chk({30'h0, gateClosed[0], contactOut}, 32'h1);
      snd.sw(1'b0);
      settle();
      chk({31'h0, contactOut}, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h0000_0701);
      snd.lc(0, 1'b0);
      settle();
      chk({31'h0, gateClosed[0]}, 32'h1);
   endtask
   task automatic t_scene();
      apb(1'b1, OFS_CTRL, 32'h1);
      apb(1'b1, OFS_SLOT_LO, 32'h0000_0905);
      apb(1'b1, OFS_SCDEF, 32'h0000_00FE);
      snd.pulse(3);
      snd.sw(1'b1);
      settle();
      snd.recall(5);
      #1;
      chk({31'h0, timerRestart}, 32'h1);
      settle();
      chk({30'h0, switchValue, contactOut}, 32'h0);
      snd.recall(9);
      settle();
      chk({31'h0, contactOut}, 32'h1);
      snd.store(5);
      snd.sw(1'b0);
      settle();
      snd.recall(5);
      settle();
      chk({31'h0, contactOut}, 32'h1);
      snd.recall(20);
      #1;
      chk({31'h0, timerRestart}, 32'h0);
      snd.pulse(3);
      snd.recall(5);
      settle();
      chk({31'h0, contactOut}, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h0);
      snd.store(9);
      snd.pulse(3);
      snd.recall(9);
      settle();
      chk({31'h0, contactOut}, 32'h0);
   endtask
   task automatic t_fail();
      apb(1'b1, OFS_CTRL, 32'h0047_0101);
      snd.lc(0, 1'b1);
      snd.lc(1, 1'b0);
      snd.sw(1'b1);
      snd.pulse(0);
      snd.pulse(1);
      settle();
      chk({29'h0, gateClosed[1], switchValue, contactOut},
          32'h5);
      snd.pulse(2);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk({31'h0, rd[12]}, 32'h1);
      for (int rec = 1; rec < 3; rec++) begin
         apb(1'b1, OFS_CTRL, 32'h0000_0101 | (32'(rec) << 12));
         snd.lc(0, rec == 1);
         snd.pulse(0);
         snd.pulse(1);
         settle();
         apb(1'b0, OFS_STATUS, 32'h0);
         chk({31'h0, rd[12]}, 32'(rec == 2));
      end
   endtask
   // ---------------------------------------------------------------
   // Sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      sys_rst <= 1'b1;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 12'h000;
      pwdata <= 32'h0;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs();
      t_unassigned();
      t_logic();
      t_gate();
      t_scene();
      t_fail();
      finish_test();
   end
   // The whole run needs well under a tenth of this ceiling.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_count++;
         finish_test();
      end
   end
endmodule // output_scene_logic_gate_tb_top
`default_nettype wire
